// file: design/hhs_defs.svh
// Processor reset timing counts and counter width for the hold and strobe block
`ifndef HHS_DEFS_SVH
`define HHS_DEFS_SVH
`define HHS_RST_DELAY_CYC 4'h3
`define HHS_RST_HOLD_CYC 5'h10
`define HHS_RST_CNT_W 5
`endif

// file: design/hhs_pkg.sv
// Types for the hold and strobe block
package hhs_pkg;
    typedef struct packed {
        logic processor_hold_request_out;
        logic grant_to_master_out;
    } hhs_hold_t;
    typedef enum logic [2:0] {
        HHS_RS_IDLE = 3'b001,
        HHS_RS_WAIT = 3'b010,
        HHS_RS_ACT = 3'b100
    } hhs_rst_state_t;
endpackage

// file: design/hhs_hold_ctrl.sv
// Hold handshake, processor reset and peripheral strobes
`timescale 1ns/1ps
`include "hhs_defs.svh"
module hhs_hold_ctrl (
    // Clock and reset
    input wire logic clk_i,
    input wire logic nrst_i,
    // Alternate masters and processor
    input wire logic master_bus_request_in_i,
    input wire logic ext_master_active_n_i,
    input wire logic processor_grant_in_i,
    output hhs_pkg::hhs_hold_t hold_o,
    // Refresh
    input wire logic refresh_cycle_n_i,
    output logic refresh_start_o,
    // Keyboard reset
    input wire logic keyboard_reset_in_n_i,
    output logic processor_reset_out_o,
    // Interrupt acknowledge and steering
    input wire logic irq_ack_cycle_i,
    output logic irq_acknowledge_n_o,
    output logic periph_to_sys_data_en_o,
    // Speaker
    input wire logic speaker_enable_i,
    input wire logic timer_tone_i,
    output logic speaker_gate_out_o
);
    logic [2:0] req_sync_reg;
    logic [2:0] mst_sync_reg;
    logic [2:0] gnt_sync_reg;
    logic [2:0] kbr_sync_reg;
    logic [2:0] ref_sync_reg;
    logic req_lvl_reg;
    logic mst_lvl_reg;
    logic gnt_lvl_reg;
    logic kbr_lvl_reg;
    logic ref_lvl_reg;
    logic hold_req_reg;
    logic hold_ack_reg;
    logic ref_start_reg;
    logic ref_prev_reg;
    logic rst_out_reg;
    logic inta_n_reg;
    logic steer_reg;
    logic spk_reg;
    logic [`HHS_RST_CNT_W-1:0] rst_cnt_reg;
    hhs_pkg::hhs_rst_state_t rst_state_reg;

    // Three-stage synchronisers; level changes once stages 2 and 3 agree
    always_ff @(posedge clk_i) begin
        if (!nrst_i) begin
            req_sync_reg <= 3'h0;
            mst_sync_reg <= 3'h7;
            gnt_sync_reg <= 3'h0;
            kbr_sync_reg <= 3'h7;
            ref_sync_reg <= 3'h7;
        end else begin
            req_sync_reg <= {req_sync_reg[1:0], master_bus_request_in_i};
            mst_sync_reg <= {mst_sync_reg[1:0], ext_master_active_n_i};
            gnt_sync_reg <= {gnt_sync_reg[1:0], processor_grant_in_i};
            kbr_sync_reg <= {kbr_sync_reg[1:0], keyboard_reset_in_n_i};
            ref_sync_reg <= {ref_sync_reg[1:0], refresh_cycle_n_i};
        end
    end

    always_ff @(posedge clk_i) begin
        if (!nrst_i) begin
            req_lvl_reg <= 1'b0;
            mst_lvl_reg <= 1'b1;
            gnt_lvl_reg <= 1'b0;
            kbr_lvl_reg <= 1'b1;
            ref_lvl_reg <= 1'b1;
        end else begin
            if (req_sync_reg[1] == req_sync_reg[2]) begin
                req_lvl_reg <= req_sync_reg[2];
            end
            if (mst_sync_reg[1] == mst_sync_reg[2]) begin
                mst_lvl_reg <= mst_sync_reg[2];
            end
            if (gnt_sync_reg[1] == gnt_sync_reg[2]) begin
                gnt_lvl_reg <= gnt_sync_reg[2];
            end
            if (kbr_sync_reg[1] == kbr_sync_reg[2]) begin
                kbr_lvl_reg <= kbr_sync_reg[2];
            end
            if (ref_sync_reg[1] == ref_sync_reg[2]) begin
                ref_lvl_reg <= ref_sync_reg[2];
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (!nrst_i) begin
            hold_req_reg <= 1'b0;
        end else begin
            hold_req_reg <= req_lvl_reg | ~mst_lvl_reg;
        end
    end

    // Acknowledge follows synced grant while requested
    always_ff @(posedge clk_i) begin
        if (!nrst_i) begin
            hold_ack_reg <= 1'b0;
        end else begin
            hold_ack_reg <= gnt_lvl_reg & hold_req_reg;
        end
    end

    assign hold_o.processor_hold_request_out = hold_req_reg;
    assign hold_o.grant_to_master_out = hold_ack_reg;

    // Refresh start on falling refresh during acknowledge
    always_ff @(posedge clk_i) begin
        if (!nrst_i) begin
            ref_prev_reg <= 1'b1;
            ref_start_reg <= 1'b0;
        end else begin
            ref_prev_reg <= ref_lvl_reg;
            ref_start_reg <= ref_prev_reg & ~ref_lvl_reg & hold_ack_reg;
        end
    end
    assign refresh_start_o = ref_start_reg;

    always_ff @(posedge clk_i) begin
        if (!nrst_i) begin
            rst_state_reg <= hhs_pkg::HHS_RS_IDLE;
            rst_cnt_reg <= '0;
            rst_out_reg <= 1'b0;
        end else begin
            case (rst_state_reg)
                hhs_pkg::HHS_RS_IDLE: begin
                    rst_out_reg <= 1'b0;
                    rst_cnt_reg <= '0;
                    if (!kbr_lvl_reg) begin
                        rst_state_reg <= hhs_pkg::HHS_RS_WAIT;
                    end
                end
                hhs_pkg::HHS_RS_WAIT: begin
                    rst_cnt_reg <= rst_cnt_reg + 1'b1;
                    if (rst_cnt_reg ==
                        `HHS_RST_CNT_W'(`HHS_RST_DELAY_CYC - 4'h1)) begin
                        rst_state_reg <= hhs_pkg::HHS_RS_ACT;
                        rst_out_reg <= 1'b1;
                        rst_cnt_reg <= '0;
                    end
                end
                hhs_pkg::HHS_RS_ACT: begin
                    rst_cnt_reg <= rst_cnt_reg + 1'b1;
                    if (!kbr_lvl_reg) begin
                        rst_cnt_reg <= '0;
                    end else if (rst_cnt_reg ==
                        `HHS_RST_HOLD_CYC - 5'h1) begin
                        rst_out_reg <= 1'b0;
                        rst_state_reg <= hhs_pkg::HHS_RS_IDLE;
                    end
                end
                default: begin
                    rst_state_reg <= hhs_pkg::HHS_RS_IDLE;
                    rst_out_reg <= 1'b0;
                end
            endcase
        end
    end
    assign processor_reset_out_o = rst_out_reg;

    always_ff @(posedge clk_i) begin
        if (!nrst_i) begin
            inta_n_reg <= 1'b1;
            steer_reg <= 1'b0;
        end else begin
            inta_n_reg <= ~irq_ack_cycle_i;
            steer_reg <= irq_ack_cycle_i;
        end
    end
    assign irq_acknowledge_n_o = inta_n_reg;
    assign periph_to_sys_data_en_o = steer_reg;

    always_ff @(posedge clk_i) begin
        if (!nrst_i) begin
            spk_reg <= 1'b0;
        end else begin
            spk_reg <= speaker_enable_i & timer_tone_i;
        end
    end
    assign speaker_gate_out_o = spk_reg;

    property p_ack_needs_grant;
        @(posedge clk_i) disable iff (!nrst_i)
        hold_ack_reg |-> $past(gnt_lvl_reg) && $past(hold_req_reg);
    endproperty
    a_ack_needs_grant: assert property (p_ack_needs_grant)
        else $error("Ack without synced grant");

    property p_req_follows;
        @(posedge clk_i) disable iff (!nrst_i)
        req_lvl_reg |=> hold_req_reg;
    endproperty
    a_req_follows: assert property (p_req_follows)
        else $error("Hold request not raised");

    property p_req_drop;
        @(posedge clk_i) disable iff (!nrst_i)
        (!req_lvl_reg && mst_lvl_reg) |=> !hold_req_reg;
    endproperty
    a_req_drop: assert property (p_req_drop)
        else $error("Hold request not dropped");

    property p_master_req;
        @(posedge clk_i) disable iff (!nrst_i)
        !mst_lvl_reg |=> hold_req_reg;
    endproperty
    a_master_req: assert property (p_master_req)
        else $error("Master did not raise hold");

    property p_ack_drop;
        @(posedge clk_i) disable iff (!nrst_i)
        !gnt_lvl_reg |=> !hold_ack_reg;
    endproperty
    a_ack_drop: assert property (p_ack_drop)
        else $error("Ack stayed after grant fell");

    property p_ref_gate;
        @(posedge clk_i) disable iff (!nrst_i)
        ref_start_reg |-> $past(hold_ack_reg) && !$past(ref_lvl_reg);
    endproperty
    a_ref_gate: assert property (p_ref_gate)
        else $error("Refresh start without ack");

    sequence s_kbr_low;
        rst_state_reg == hhs_pkg::HHS_RS_IDLE && !kbr_lvl_reg;
    endsequence
    property p_kbr_reset;
        @(posedge clk_i) disable iff (!nrst_i)
        s_kbr_low |-> ##[1:5] rst_out_reg;
    endproperty
    a_kbr_reset: assert property (p_kbr_reset)
        else $error("Processor reset not raised");

    property p_inta;
        @(posedge clk_i) disable iff (!nrst_i)
        irq_ack_cycle_i |=> !inta_n_reg && steer_reg;
    endproperty
    a_inta: assert property (p_inta)
        else $error("Interrupt acknowledge missing");

    property p_spk;
        @(posedge clk_i) disable iff (!nrst_i)
        spk_reg |-> $past(speaker_enable_i);
    endproperty
    a_spk: assert property (p_spk)
        else $error("Speaker gated while disabled");

    property p_sync_lat;
        @(posedge clk_i) disable iff (!nrst_i)
        $rose(gnt_lvl_reg) |->
            $past(gnt_sync_reg[2]) && $past(gnt_sync_reg[1]);
    endproperty
    a_sync_lat: assert property (p_sync_lat)
        else $error("Grant not synchronised");
endmodule

// file: test/hhs_cpu_model.sv
// Processor model answering hold requests with a grant
`timescale 1ns/1ps
module hhs_cpu_model (
    // Clock
    input wire logic clk_i,
    // Hold handshake
    input wire logic hold_req_i,
    input wire logic [3:0] lag_i,
    output logic grant_o
);
    logic [3:0] wait_cnt;
    initial begin
        grant_o = 1'b0;
        wait_cnt = 4'h0;
    end
    always @(posedge clk_i) begin
        #1;
        if (hold_req_i !== grant_o) begin
            if (wait_cnt >= lag_i) begin
                grant_o <= hold_req_i;
                wait_cnt <= 4'h0;
            end else begin
                wait_cnt <= wait_cnt + 4'h1;
            end
        end else begin
            wait_cnt <= 4'h0;
        end
    end
endmodule

// file: test/hhs_hold_ctrl_test.sv
// Self-checking bench for the hold and strobe block
`timescale 1ns/1ps
module hhs_hold_ctrl_test;
    logic clk_i, nrst_i, req, ext_n, gnt, rf_n, kbd_n, iac, spe, tone;
    logic rs, pr, ia_n, st, sp, hq, ha;
    logic [3:0] lag;
    logic [4:0] rq_h, gn_h;
    logic hold_e, ack_e, ia_e, st_e, sp_e;
    hhs_pkg::hhs_hold_t hold;
    int failures, num_checks, warm, pr_w, rs_n;
    hhs_hold_ctrl hhs_hold_ctrl_inst (.clk_i(clk_i), .nrst_i(nrst_i),
        .master_bus_request_in_i(req), .ext_master_active_n_i(ext_n),
        .processor_grant_in_i(gnt), .hold_o(hold),
        .refresh_cycle_n_i(rf_n), .refresh_start_o(rs),
        .keyboard_reset_in_n_i(kbd_n), .processor_reset_out_o(pr),
        .irq_ack_cycle_i(iac), .irq_acknowledge_n_o(ia_n),
        .periph_to_sys_data_en_o(st), .speaker_enable_i(spe),
        .timer_tone_i(tone), .speaker_gate_out_o(sp));
    hhs_cpu_model hhs_cpu_model_inst (.clk_i(clk_i),
        .hold_req_i(hold.processor_hold_request_out), .lag_i(lag),
        .grant_o(gnt));
    assign hq = hold.processor_hold_request_out;
    assign ha = hold.grant_to_master_out;
    initial begin
        clk_i = 1'b0;
        forever #50 clk_i = ~clk_i;
    end
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        num_checks++;
        if (got !== exp) begin
            failures++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic stop_test();
        $display("checks=%0d failures=%0d", num_checks, failures);
        if (failures == 0 && num_checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    task automatic step(input int n);
        repeat (n) @(posedge clk_i);
        #1;
    endtask
    // Reference model of the hold, interrupt acknowledge, steering and speaker outputs
    always @(posedge clk_i) begin
        if (!nrst_i) begin
            {rq_h, gn_h, hold_e, ack_e, st_e, sp_e} = '0;
            ia_e = 1'b1;
            warm = 0;
        end else begin
            rq_h = {rq_h[3:0], req | ~ext_n};
            gn_h = {gn_h[3:0], gnt};
            ack_e = hold_e & gn_h[4];
            hold_e = rq_h[4];
            {ia_e, st_e, sp_e} = {~iac, iac, spe & tone};
            warm++;
        end
    end
    always @(negedge clk_i) begin
        pr_w += (pr === 1'b1);
        rs_n += (rs === 1'b1);
        if (warm >= 6) begin
            chk(8'(hq), 8'(hold_e));
            chk(8'(ha), 8'(ack_e));
        end
        if (warm >= 1) begin
            chk({6'h0, ia_n, st}, {6'h0, ia_e, st_e});
            chk(8'(sp), 8'(sp_e));
        end
    end
    task automatic refr(input int exp);
        rs_n = 0;
        rf_n = 1'b0;
        step(8);
        rf_n = 1'b1;
        step(10);
        chk(8'(rs_n), 8'(exp));
    endtask
    task automatic kbd(input int len);
        int exp;
        pr_w = 0;
        kbd_n = 1'b0;
        step(len);
        kbd_n = 1'b1;
        step(40);
        // Rises 8 edges in; falls 16 after entry or after synced release
        exp = (len > 4) ? len + 12 : 16;
        chk(8'(pr_w), 8'(exp));
    endtask
    initial begin
        {nrst_i, req, iac, spe, tone, lag} = '0;
        {ext_n, rf_n, kbd_n} = 3'h7;
        {failures, num_checks, pr_w, rs_n, warm} = '0;
        void'($urandom(32'h485f_e8f5));
        step(4);
        nrst_i = 1'b1;
        step(8);
        for (int i = 0; i < 2; i++) begin
            lag = i ? 4'h7 : 4'h0;
            req = 1'b1;
            step(30);
            req = 1'b0;
            step(25);
        end
        ext_n = 1'b0;
        step(30);
        ext_n = 1'b1;
        step(25);
        $display("handshake test done");
        req = 1'b1;
        step(25);
        refr(1);
        req = 1'b0;
        step(25);
        refr(0);
        $display("refresh test done");
        kbd(2);
        kbd(9);
        $display("keyboard reset test done");
        repeat (10) begin
            req = 1'($urandom);
            lag = 4'($urandom & 7);
            repeat (8) begin
                {iac, spe, tone} = 3'($urandom);
                step(1);
            end
        end
        req = 1'b0;
        step(25);
        $display("random test done");
        stop_test();
    end
    initial begin
        #(100 * 3000);
        failures++;
        stop_test();
    end
endmodule
